// ===== fbmc_ctrl.sv
`timescale 1ns/1ps
// ==========================================================================
// Host-side controller for an asynchronous parallel flash.
// The user issues one bus cycle at a time: a read, a write, or a hardware
// reset. Command sequences (fast-program, erase, identification) are
// composed by the user from single writes; this block only times them.
// ==========================================================================
module fbmc_ctrl import fbmc_pkg::*; #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  // Clock, reset and enable.
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // User request port.
  input wire logic req_in,
  input wire logic [2:0] op_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic byte_mode_in,
  output logic ready_out,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  output logic flash_busy_out,
  // Flash pins.
  output logic [ADDR_W-1:0] fl_addr_out,
  output logic fl_byte_n_out,
  output logic fl_select_n_out,
  output logic fl_gate_n_out,
  output logic fl_write_n_out,
  output logic fl_reset_n_out,
  output logic [DATA_W-1:0] fl_dq_out,
  output logic [DATA_W-1:0] fl_dq_oe_out,
  input wire logic [DATA_W-1:0] fl_dq_in,
  input wire logic fl_ready_busy_n_in
);

  // Widths that the logic assumes; other values are refused at elaboration.
  if (DATA_W != 16 || ADDR_W < 2) begin : g_bad_width
    $error("fbmc_ctrl: DATA_W must be 16 and ADDR_W at least 2");
  end

  // ========================================================================
  // State and decode.
  // ========================================================================
  fbmc_state_t state, next_state;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic tmr_done;
  wire take = ready_out && req_in;
  wire is_read = (op_in == OP_READ);
  wire is_write = (op_in == OP_WRITE);
  // In byte mode only the low byte carries data and the top line is address.
  wire [DATA_W-1:0] dq_drive = byte_mode_in ? {addr_in[0], 7'h00, wdata_in[7:0]} : wdata_in;
  wire [DATA_W-1:0] dq_en_w = byte_mode_in ? 16'h80ff : 16'hffff;
  wire [DATA_W-1:0] dq_en_r = byte_mode_in ? 16'h8000 : 16'h0000;

  // The timer leaves reset loaded with the pulse width, so the boot pulse on
  // the reset line is as long as a requested one and not just one cycle.
  fbmc_timer #(.W(CNT_W), .RESET_COUNT(CNT_W'(RESET_PULSE_MIN_CYC))) u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .load_in(tmr_load),
    .value_in(tmr_value),
    .done_out(tmr_done)
  );

  // ========================================================================
  // Next state; the timer is loaded on every state change except a return to ST_IDLE.
  // ========================================================================
  always_comb begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_value = '0;
    unique case (state)
      ST_RST: begin
        // Reset line held low for the full minimum pulse.
        if (tmr_done) begin
          next_state = ST_RECOV;
          tmr_load = 1'b1;
          tmr_value = CNT_W'(READ_AFTER_RESET_CYC);
        end
      end
      ST_RECOV: begin
        // Wait the read delay and, after an aborted operation, busy to clear.
        // After a reset, ready returns only from here, so the user knows when a cut operation may be restarted.
        if (tmr_done && fl_ready_busy_n_in) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take && op_in == OP_RESET) begin
          next_state = ST_RST;
          tmr_load = 1'b1;
          tmr_value = CNT_W'(RESET_PULSE_MIN_CYC);
        end else if (take && is_read) begin
          next_state = ST_READ;
          tmr_load = 1'b1;
          tmr_value = CNT_W'(SELECT_ACCESS_CYC);
        end else if (take && is_write) begin
          next_state = ST_WLOW;
          tmr_load = 1'b1;
          tmr_value = CNT_W'(WRITE_PULSE_CYC);
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_WLOW: begin
        if (tmr_done) begin
          next_state = ST_WHIGH;
          tmr_load = 1'b1;
          tmr_value = CNT_W'(WRITE_RECOVER_CYC);
        end
      end
      ST_WHIGH: begin
        // Writes may follow back to back, so a fast-program pair is two requests.
        if (tmr_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_RST;
        tmr_load = 1'b1;
        tmr_value = CNT_W'(RESET_PULSE_MIN_CYC);
      end
    endcase
  end

  // ========================================================================
  // State register. Reset starts with a device reset pulse so the flash is
  // in array read before the first access.
  // ========================================================================
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= ST_RST;
    end else if (ce_in) begin
      state <= next_state;
    end
  end

  // ========================================================================
  // Pin and user outputs, all registered.
  // ========================================================================
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      fl_reset_n_out <= 1'b0;
      fl_select_n_out <= 1'b1;
      fl_gate_n_out <= 1'b1;
      fl_write_n_out <= 1'b1;
      fl_addr_out <= '0;
      fl_byte_n_out <= 1'b1;
      fl_dq_out <= '0;
      fl_dq_oe_out <= '0;
      ready_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= '0;
      flash_busy_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      flash_busy_out <= !fl_ready_busy_n_in;
      // An unknown op code leaves the sequencer idle, so ready does not flicker.
      ready_out <= (next_state == ST_IDLE);
      // Reset line low only in the pulse state.
      fl_reset_n_out <= (next_state != ST_RST);
      // Select only once reset has returned high.
      fl_select_n_out <= !(next_state == ST_READ || next_state == ST_WLOW || next_state == ST_WHIGH);
      // Gate low only for reads, never during writes.
      fl_gate_n_out <= (next_state != ST_READ);
      fl_write_n_out <= (next_state != ST_WLOW);
      if (state == ST_IDLE && take && (is_read || is_write)) begin
        fl_addr_out <= addr_in;
        fl_byte_n_out <= !byte_mode_in;
        fl_dq_out <= dq_drive;
        fl_dq_oe_out <= is_write ? dq_en_w : dq_en_r;
      end
      if (state == ST_READ && tmr_done) begin
        // Status and identification reads use this same timing.
        rdata_out <= fl_byte_n_out ? fl_dq_in : {8'h00, fl_dq_in[7:0]};
        done_out <= 1'b1;
        fl_dq_oe_out <= '0;
      end
      if (state == ST_WHIGH && tmr_done) begin
        done_out <= 1'b1;
        fl_dq_oe_out <= '0;
      end
    end
  end

  // ========================================================================
  // Checks.
  // ========================================================================
  property p_write_gate;
    @(posedge clk_in) disable iff (!resetn_in) !fl_write_n_out |-> (fl_gate_n_out && !fl_select_n_out);
  endproperty
  a_write_gate: assert property (p_write_gate) else $error("write with gate low");

  property p_select_after_reset;
    @(posedge clk_in) disable iff (!resetn_in) !fl_select_n_out |-> fl_reset_n_out;
  endproperty
  a_select_after_reset: assert property (p_select_after_reset) else $error("select during reset");

  property p_reset_width;
    @(posedge clk_in) disable iff (!resetn_in) (ce_in && $fell(fl_reset_n_out)) |-> !fl_reset_n_out[*8];
  endproperty
  a_reset_width: assert property (p_reset_width) else $error("reset pulse too short");

  property p_read_wait;
    @(posedge clk_in) disable iff (!resetn_in) (ce_in && $rose(fl_reset_n_out)) |-> fl_select_n_out[*8];
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("access too soon after reset");

  property p_read_gate;
    @(posedge clk_in) disable iff (!resetn_in) !fl_gate_n_out |-> (fl_write_n_out && !fl_select_n_out);
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("bad read strobes");

  property p_byte_top;
    @(posedge clk_in) disable iff (!resetn_in) (!fl_byte_n_out && !fl_select_n_out) |-> fl_dq_oe_out[15];
  endproperty
  a_byte_top: assert property (p_byte_top) else $error("top line not driven in byte mode");

  property p_busy_hold;
    @(posedge clk_in) disable iff (!resetn_in) (state == ST_RECOV && !fl_ready_busy_n_in) |=> state != ST_IDLE;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("left recovery while busy");

  property p_boot_reset;
    @(posedge clk_in) disable iff (!resetn_in) (ce_in && $rose(ready_out)) |-> fl_reset_n_out;
  endproperty
  a_boot_reset: assert property (p_boot_reset) else $error("ready during reset");

endmodule : fbmc_ctrl

// ===== fbmc_flash_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Behavioural flash device, seen only through its pins.
// ==========================================================================
module fbmc_flash_model #(
  parameter logic [15:0] BUSY_CMD = 16'h0030,
  parameter logic [15:0] STATUS = 16'h0080,
  parameter int BUSY_CYC = 60
) (
  // Clock of the sampling model.
  input wire logic clk_in,
  // Device pins.
  input wire logic [19:0] addr_in,
  input wire logic byte_n_in,
  input wire logic select_n_in,
  input wire logic gate_n_in,
  input wire logic write_n_in,
  input wire logic reset_n_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic ready_busy_n_out
);
  logic [15:0] mem [16]; // Small array on the low address bits.
  logic [15:0] last = 16'h0000; // Last wire value, inverted when floating.
  logic wr_d = 1'b1; // Write strobe one cycle back.
  int busy = 0; // Cycles left of the embedded operation.
  // In byte mode the top data line is the lowest address bit.
  wire [3:0] idx = byte_n_in ? addr_in[3:0] : {addr_in[2:0], dq_in[15]};
  wire drive = !select_n_in && !gate_n_in && write_n_in && reset_n_in;
  wire [15:0] word = (busy > 0) ? STATUS : mem[idx];
  // A floating line never keeps its old value, so stale data cannot pass.
  assign dq_out = !drive ? ~last : (byte_n_in ? word : {~last[15:8], word[7:0]});
  assign ready_busy_n_out = (busy == 0);
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // Write capture on the strobe's rising edge; busy countdown.
  always @(posedge clk_in) begin
    wr_d <= write_n_in;
    last <= dq_out;
    if (!reset_n_in && busy > 8) busy <= 8;
    else if (busy > 0) busy <= busy - 1;
    if (reset_n_in && !select_n_in && gate_n_in && !wr_d && write_n_in) begin
      mem[idx] <= byte_n_in ? dq_in : {8'h00, dq_in[7:0]};
      if (dq_in == BUSY_CMD) busy <= BUSY_CYC;
    end
  end
endmodule : fbmc_flash_model

// ===== fbmc_pkg.sv
// ==========================================================================
// ==========================================================================
package fbmc_pkg;

  // ========================================================================
  // Bus timing, in nanoseconds, and derived cycle counts at 100 MHz.
  // ========================================================================
  localparam int CLK_PERIOD_NS = 10;
  // Access time from select or address to valid data.
  localparam int SELECT_ACCESS_TIME_NS = 70;
  localparam int SELECT_ACCESS_CYC = (SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Write strobe low width and the recovery high time after it.
  localparam int WRITE_PULSE_NS = 40;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_RECOVER_NS = 30;
  localparam int WRITE_RECOVER_CYC = (WRITE_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Minimum reset pulse width.
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_PULSE_MIN_CYC = (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Delay from reset line rising to the first read.
  localparam int READ_AFTER_RESET_DELAY_NS = 200;
  localparam int READ_AFTER_RESET_CYC = (READ_AFTER_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Width of the cycle counter that covers all the above.
  localparam int CNT_W = 8;

  // ========================================================================
  // User operation codes.
  // ========================================================================
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_RESET = 3'h2;

  // ========================================================================
  // Sequencer states, one-hot.
  // ========================================================================
  typedef enum logic [5:0] {
    ST_RST = 6'h01,
    ST_RECOV = 6'h02,
    ST_IDLE = 6'h04,
    ST_READ = 6'h08,
    ST_WLOW = 6'h10,
    ST_WHIGH = 6'h20
  } fbmc_state_t;

endpackage : fbmc_pkg

// ===== fbmc_timer.sv
`timescale 1ns/1ps
// ==========================================================================
// Down counter that times each bus phase.
// ==========================================================================
module fbmc_timer import fbmc_pkg::*; #(
  parameter int W = CNT_W,
  // Count held while in reset, so the first phase after reset is timed too.
  parameter logic [W-1:0] RESET_COUNT = '0
) (
  // Clock, reset and enable.
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // Load and status.
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  output logic done_out
);

  // Remaining cycles of the phase under way.
  logic [W-1:0] count;

  // Done is high when the count has run out; loading takes priority.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      count <= RESET_COUNT;
    end else if (ce_in) begin
      if (load_in) begin
        count <= value_in;
      end else if (count != '0) begin
        count <= count - 1'b1;
      end
    end
  end

  assign done_out = (count == '0);

endmodule : fbmc_timer

// ===== tb_top.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the flash bus controller.
// ==========================================================================
module tb_top;
  import fbmc_pkg::*;
  localparam logic [15:0] BUSY_CMD = 16'h0030; // Starts a model operation.
  localparam logic [15:0] STATUS = 16'h0080; // Status seen while busy.
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic ce_in = 1'b1;
  logic req_in = 1'b0;
  logic [2:0] op_in = OP_READ;
  logic [19:0] addr_in = 20'h00000;
  logic [15:0] wdata_in = 16'h0000;
  logic byte_mode_in = 1'b0;
  logic ready_out, done_out, flash_busy_out, fl_byte_n_out, fl_select_n_out;
  logic fl_gate_n_out, fl_write_n_out, fl_reset_n_out, fl_rb_n;
  logic [15:0] rdata_out, fl_dq_out, fl_dq_oe_out, m_dq, fl_dq_in;
  logic [19:0] fl_addr_out;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int lat;
  // The wire takes each bit from whoever enables it.
  assign fl_dq_in = (fl_dq_oe_out & fl_dq_out) | (~fl_dq_oe_out & m_dq);
  fbmc_ctrl DUT (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .req_in(req_in), .op_in(op_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .byte_mode_in(byte_mode_in), .ready_out(ready_out),
    .done_out(done_out), .rdata_out(rdata_out), .flash_busy_out(flash_busy_out), .fl_addr_out(fl_addr_out),
    .fl_byte_n_out(fl_byte_n_out), .fl_select_n_out(fl_select_n_out), .fl_gate_n_out(fl_gate_n_out),
    .fl_write_n_out(fl_write_n_out), .fl_reset_n_out(fl_reset_n_out), .fl_dq_out(fl_dq_out),
    .fl_dq_oe_out(fl_dq_oe_out), .fl_dq_in(fl_dq_in), .fl_ready_busy_n_in(fl_rb_n));
  fbmc_flash_model #(.BUSY_CMD(BUSY_CMD), .STATUS(STATUS), .BUSY_CYC(60)) MODEL (.clk_in(clk_in),
    .addr_in(fl_addr_out), .byte_n_in(fl_byte_n_out), .select_n_in(fl_select_n_out), .gate_n_in(fl_gate_n_out),
    .write_n_in(fl_write_n_out), .reset_n_in(fl_reset_n_out), .dq_in(fl_dq_in), .dq_out(m_dq),
    .ready_busy_n_out(fl_rb_n));
  // ========================================================================
  // Shared tasks.
  // ========================================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle; lat counts cycles from take to the done pulse.
  task automatic xfer(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req_in <= 1'b1;
    op_in <= o;
    addr_in <= a;
    wdata_in <= d;
    @(negedge clk_in);
    while (ready_out !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    req_in <= 1'b0;
    lat = 0;
    if (o != OP_RESET) begin
      do begin
        @(negedge clk_in);
        lat++;
        if (lat == 1) chk({15'h0, ready_out}, 16'h0000);
      end while (done_out !== 1'b1 && lat < 30);
      // Each timed phase lasts its count plus the edge that loads it; the
      // first look is one falling edge after the take.
      chk(lat[15:0], (o == OP_READ) ? 16'(SELECT_ACCESS_CYC + 2) : 16'(WRITE_PULSE_CYC + WRITE_RECOVER_CYC + 3));
    end
  endtask : xfer
  task automatic finish_test;
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // ========================================================================
  // Scenarios.
  // ========================================================================
  // Word write then back-to-back reads of two places.
  task automatic t_word;
    xfer(OP_WRITE, 20'h00003, 16'hbeef);
    xfer(OP_WRITE, 20'h00006, 16'h0f0f);
    xfer(OP_READ, 20'h00003, 16'h0000);
    chk(rdata_out, 16'hbeef);
    xfer(OP_READ, 20'h00006, 16'h0000);
    chk(rdata_out, 16'h0f0f);
  endtask : t_word
  // Byte mode: the lowest address bit must travel on the top data line.
  task automatic t_byte;
    byte_mode_in <= 1'b1;
    xfer(OP_WRITE, 20'h00005, 16'hff5a);
    xfer(OP_WRITE, 20'h00004, 16'h0011);
    xfer(OP_READ, 20'h00005, 16'h0000);
    chk({8'h00, rdata_out[7:0]}, 16'h005a);
    xfer(OP_READ, 20'h00004, 16'h0000);
    chk({8'h00, rdata_out[7:0]}, 16'h0011);
    byte_mode_in <= 1'b0;
  endtask : t_byte
  // A status read while the device is busy, then normal data again.
  task automatic t_busy;
    xfer(OP_WRITE, 20'h00001, BUSY_CMD);
    @(negedge clk_in);
    chk({15'h0, flash_busy_out}, 16'h0001);
    xfer(OP_READ, 20'h00001, 16'h0000);
    chk({8'h00, rdata_out[7:0]}, STATUS);
    lat = 0;
    while (flash_busy_out !== 1'b0 && lat < 200) begin
      @(negedge clk_in);
      lat++;
    end
    chk({15'h0, flash_busy_out}, 16'h0000);
    xfer(OP_READ, 20'h00001, 16'h0000);
    chk(rdata_out, BUSY_CMD);
  endtask : t_busy
  // Reset pulse in mid-operation: pin low, busy ends, array read returns.
  task automatic t_reset;
    xfer(OP_WRITE, 20'h00002, 16'h1234);
    xfer(OP_WRITE, 20'h00001, BUSY_CMD);
    xfer(OP_RESET, 20'h00000, 16'h0000);
    repeat (2) @(negedge clk_in);
    chk({15'h0, fl_reset_n_out}, 16'h0000);
    lat = 0;
    while (ready_out !== 1'b1 && lat < 400) begin
      @(negedge clk_in);
      lat++;
    end
    chk({15'h0, lat >= 70}, 16'h0001);
    chk({15'h0, flash_busy_out}, 16'h0000);
    xfer(OP_READ, 20'h00002, 16'h0000);
    chk(rdata_out, 16'h1234);
  endtask : t_reset
  // An unknown op code is ignored: the flash is never selected.
  task automatic t_refuse;
    @(posedge clk_in);
    req_in <= 1'b1;
    op_in <= 3'h3;
    repeat (12) begin
      @(negedge clk_in);
      chk({15'h0, fl_select_n_out | done_out === 1'b0}, 16'h0001);
      chk({15'h0, ready_out}, 16'h0001);
    end
    @(posedge clk_in);
    req_in <= 1'b0;
  endtask : t_refuse
  // Clock enable low in mid-read: pins and timer hold, the read then finishes.
  task automatic t_freeze;
    @(posedge clk_in);
    req_in <= 1'b1;
    op_in <= OP_READ;
    addr_in <= 20'h00003;
    @(negedge clk_in);
    while (ready_out !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    req_in <= 1'b0;
    ce_in <= 1'b0;
    repeat (20) begin
      @(negedge clk_in);
      chk({14'h0, fl_select_n_out, done_out}, 16'h0000);
    end
    @(posedge clk_in);
    ce_in <= 1'b1;
    lat = 0;
    do begin
      @(negedge clk_in);
      lat++;
    end while (done_out !== 1'b1 && lat < 30);
    chk(lat[15:0], 16'(SELECT_ACCESS_CYC + 2));
    chk(rdata_out, 16'hbeef);
  endtask : t_freeze
  // ========================================================================
  // Clock, hang guard and main sequence.
  // ========================================================================
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // A hang counts as a mismatch and goes to the verdict.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_word();
    t_byte();
    t_busy();
    t_reset();
    t_refuse();
    t_freeze();
    finish_test();
  end
endmodule : tb_top
